// ---- design/lsd_pkg.sv ----
package lsd_pkg;
   // ----------------------------------------------------------------
   // general sizing
   // ----------------------------------------------------------------
   localparam int unsigned LSD_NSTR = 6;
   localparam int unsigned LSD_CLK_HZ = 25000000;
   localparam int unsigned LSD_DUTY_W = 8;
   localparam logic [7:0] LSD_DUTY_MAX = 8'h00_FF;
   localparam logic [7:0] LSD_DUTY_RST = 8'h00_00;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] LSD_REG_CTRL = 12'h0_000;
   localparam logic [11:0] LSD_REG_PERIOD = 12'h0_004;
   localparam logic [11:0] LSD_REG_OCLIM = 12'h0_008;
   localparam logic [11:0] LSD_REG_STATUS = 12'h0_00C;
   localparam logic [11:0] LSD_REG_DUTY = 12'h0_010;
   localparam logic [11:0] LSD_REG_ID = 12'h0_014;

   // ctrl field positions
   localparam int unsigned LSD_CTRL_EN_BIT = 0;

   // status field positions
   localparam int unsigned LSD_ST_DIRECT_BIT = 0;
   localparam int unsigned LSD_ST_SHUT_BIT = 1;
   localparam int unsigned LSD_ST_OC_BIT = 2;
   localparam int unsigned LSD_ST_SHORT_BIT = 3;
   localparam int unsigned LSD_ST_OT_BIT = 4;
   localparam int unsigned LSD_ST_PWMSEEN_BIT = 5;
   localparam int unsigned LSD_ST_DIS_LSB = 8;
   localparam int unsigned LSD_ST_USED_LSB = 16;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [23:0] LSD_PERIOD_RST = 24'h01_E848; // 125000 clk = 200 Hz
   localparam logic [7:0] LSD_OCLIM_RST = 8'h00_08;
   // arbitrary neutral identity value
   localparam logic [31:0] LSD_ID_VALUE = 32'h0000_1234;

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LSD_OFF = 2'b00,
      LSD_CHECK = 2'b01,
      LSD_WAIT_PWM = 2'b10,
      LSD_RUN = 2'b11
   } lsd_state_t;
endpackage

// ---- design/lsd_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - strap on frequency/mode pin picks phase shift (default) or direct dimming.
// - phase shift mode staggers used strings by period over used count.
// - phase shift mode measures input duty into an 8-bit stored code.
// - per-string duty is regenerated from the stored code on every used sink.
// - one LSB hysteresis: rise in 1/256 steps, fall only in 2/256.
// - direct mode drives used strings in lockstep with input PWM.
// - output over-voltage sense inhibits switching while it persists.
// - string with no sink current is open, disabled, dropped from feedback.
// - string sink over-voltage turns that sink off and drops it.
// - string faults shut down the device only when all strings open.
// - disabled strings stay off until reset or enable toggle.
// - current limit ends switch pulse until next switching cycle.
// - sustained over-current latches device off until reset or toggle.
// - output short shuts device down at once, latched.
// - over-temperature shuts down at once, latched.
// - duty decoder is disabled in direct mode.
// - at startup unused channels are shut and not counted.
// - no dimming PWM after enable keeps output minimal until PWM appears.
// - enable low shuts down; low-then-high clears latched faults.
module lsd_top
   import lsd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enable_pin,
   input wire logic dim_pwm_in,
   input wire logic dim_freq_mode_pin,
   input wire logic [LSD_NSTR-1:0] string_sink_feedback,
   input wire logic [LSD_NSTR-1:0] string_sink_overvoltage,
   input wire logic output_overvoltage_sense,
   input wire logic switch_cycle_start,
   input wire logic switch_current_limit,
   input wire logic output_short,
   input wire logic over_temperature,
   output logic [LSD_NSTR-1:0] sink_on,
   output logic [LSD_NSTR-1:0] fb_select,
   output logic boost_switch_on,
   output logic boost_min_output,
   output logic device_shutdown
);
   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic sw_enable;
   logic [23:0] dim_period;
   logic [7:0] oc_limit;
   lsd_state_t state;
   logic direct_mode;
   logic en_d;
   logic en_active;
   logic en_rise;
   logic [LSD_NSTR-1:0] used;
   logic [LSD_NSTR-1:0] disabled;
   logic [LSD_NSTR-1:0] live;
   logic [2:0] n_used;
   logic oc_latch;
   logic short_latch;
   logic ot_latch;
   logic all_open;
   logic fault_shut;
   logic [7:0] oc_run;
   logic pwm_d;
   logic pwm_seen;
   logic [23:0] in_cnt;
   logic [23:0] in_high;
   logic [7:0] meas;
   logic [7:0] duty_code;
   logic [23:0] ph_cnt;
   logic [23:0] slot;
   logic [31:0] duty_time;
   logic [LSD_NSTR-1:0] ps_on;
   logic sw_gate;
   logic acc;

   assign acc = psel & penable;
   assign en_active = enable_pin & sw_enable;
   assign en_rise = en_active & ~en_d;
   assign live = used & ~disabled;
   assign all_open = (live == '0) && (state == LSD_RUN);
   assign fault_shut = oc_latch | short_latch | ot_latch;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // control writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_enable <= 1'b1;
         dim_period <= LSD_PERIOD_RST;
         oc_limit <= LSD_OCLIM_RST;
      end else if (acc && pwrite) begin
         case (paddr)
            LSD_REG_CTRL: sw_enable <= pwdata[LSD_CTRL_EN_BIT];
            LSD_REG_PERIOD: dim_period <= pwdata[23:0];
            LSD_REG_OCLIM: oc_limit <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // read mux, combinational so data lands in the access cycle
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         LSD_REG_CTRL: prdata[LSD_CTRL_EN_BIT] = sw_enable;
         LSD_REG_PERIOD: prdata[23:0] = dim_period;
         LSD_REG_OCLIM: prdata[7:0] = oc_limit;
         LSD_REG_STATUS: begin
            prdata[LSD_ST_DIRECT_BIT] = direct_mode;
            prdata[LSD_ST_SHUT_BIT] = device_shutdown;
            prdata[LSD_ST_OC_BIT] = oc_latch;
            prdata[LSD_ST_SHORT_BIT] = short_latch;
            prdata[LSD_ST_OT_BIT] = ot_latch;
            prdata[LSD_ST_PWMSEEN_BIT] = pwm_seen;
            prdata[LSD_ST_DIS_LSB +: LSD_NSTR] = disabled;
            prdata[LSD_ST_USED_LSB +: LSD_NSTR] = used;
         end
         LSD_REG_DUTY: prdata[7:0] = duty_code;
         LSD_REG_ID: prdata = LSD_ID_VALUE;
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // enable, strap and sequencing
   // ----------------------------------------------------------------
   // enable edge tracker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_d <= 1'b0;
      end else begin
         en_d <= en_active;
      end
   end

   // strap caught on each enable rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direct_mode <= 1'b0;
      end else if (en_rise) begin
         direct_mode <= dim_freq_mode_pin;
      end
   end

   // main sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LSD_OFF;
      end else begin
         case (state)
            LSD_OFF: if (en_rise) state <= LSD_CHECK;
            LSD_CHECK: state <= LSD_WAIT_PWM;
            LSD_WAIT_PWM: if (pwm_seen) state <= LSD_RUN;
            LSD_RUN: ;
            default: state <= LSD_OFF;
         endcase
         if (!en_active) state <= LSD_OFF;
      end
   end

   // used channel survey at startup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         used <= '0;
      end else if (state == LSD_CHECK) begin
         used <= string_sink_feedback;
      end
   end

   // channel count from survey
   always_comb begin
      n_used = 3'd0;
      for (int i = 0; i < LSD_NSTR; i++) begin
         n_used = n_used + {2'b00, used[i]};
      end
   end

   // ----------------------------------------------------------------
   // per-string fault latches
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < LSD_NSTR; g++) begin : g_str
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               disabled[g] <= 1'b0;
            end else if (en_rise) begin
               disabled[g] <= 1'b0;
            end else if (state == LSD_RUN && used[g]) begin
               // open: sink on but no current; over-voltage: sink off
               if ((sink_on[g] && !string_sink_feedback[g]) ||
                   string_sink_overvoltage[g]) begin
                  disabled[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // device fault latches
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_latch <= 1'b0;
         short_latch <= 1'b0;
         ot_latch <= 1'b0;
         oc_run <= 8'h00;
      end else if (en_rise) begin
         // a short or over-temperature still present at the clear wins over the clear; over-current always clears
         oc_latch <= 1'b0;
         short_latch <= output_short;
         ot_latch <= over_temperature;
         oc_run <= 8'h00;
      end else begin
         if (output_short) short_latch <= 1'b1;
         if (over_temperature) ot_latch <= 1'b1;
         if (switch_cycle_start) begin
            if (!sw_gate && boost_switch_on == 1'b0 && oc_run != 8'h00) begin
               oc_run <= oc_run;
            end
         end
         if (switch_current_limit && sw_gate) begin
            if (oc_run + 8'h01 >= oc_limit) oc_latch <= 1'b1;
            oc_run <= oc_run + 8'h01;
         end else if (switch_cycle_start && sw_gate) begin
            oc_run <= 8'h00; // cycle ended without limit
         end
      end
   end

   // pulse-by-pulse gate: set at cycle start, cut at limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_gate <= 1'b0;
      end else if (switch_cycle_start) begin
         sw_gate <= 1'b1;
      end else if (switch_current_limit) begin
         sw_gate <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // input pwm decoder
   // ----------------------------------------------------------------
   // edge tracking, presence and period/high counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_d <= 1'b0;
         pwm_seen <= 1'b0;
         in_cnt <= 24'h00_0000;
         in_high <= 24'h00_0000;
         meas <= LSD_DUTY_RST;
      end else begin
         pwm_d <= dim_pwm_in;
         if (state == LSD_OFF) begin
            pwm_seen <= 1'b0;
         end else if (dim_pwm_in) begin
            pwm_seen <= 1'b1;
         end
         if (direct_mode || state != LSD_RUN) begin
            in_cnt <= 24'h00_0000;
            in_high <= 24'h00_0000;
         end else if (dim_pwm_in && !pwm_d) begin
            // rising edge closes one input period
            if (in_cnt != 24'h00_0000) begin
               meas <= 8'((32'(in_high) * 32'd256) / 32'(in_cnt));
               if (in_high == in_cnt) meas <= LSD_DUTY_MAX;
            end
            in_cnt <= 24'h00_0001;
            in_high <= 24'h00_0001;
         end else begin
            in_cnt <= in_cnt + 24'h00_0001;
            if (dim_pwm_in) in_high <= in_high + 24'h00_0001;
         end
      end
   end

   // stored code with hysteresis
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_code <= LSD_DUTY_RST;
      end else if (!direct_mode) begin
         if (meas > duty_code) begin
            duty_code <= meas;
         end else if (duty_code >= 8'h02 && meas <= duty_code - 8'h02) begin
            duty_code <= meas;
         end
      end
   end

   // ----------------------------------------------------------------
   // phase shift generator
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_cnt <= 24'h00_0000;
      end else if (ph_cnt + 24'h00_0001 >= dim_period) begin
         ph_cnt <= 24'h00_0000;
      end else begin
         ph_cnt <= ph_cnt + 24'h00_0001;
      end
   end

   assign slot = (n_used == 3'd0) ? dim_period : dim_period / {21'd0, n_used};
   assign duty_time = (32'(dim_period) * 32'(duty_code)) / 32'd256;

   // staggered window per used string
   always_comb begin
      int k;
      logic [24:0] off;
      logic [24:0] rel;
      k = 0;
      off = 25'd0;
      rel = 25'd0;
      ps_on = '0;
      for (int i = 0; i < LSD_NSTR; i++) begin
         off = 25'(32'(slot) * 32'(k));
         rel = (25'(ph_cnt) >= off) ? 25'(ph_cnt) - off : 25'(ph_cnt) + 25'(dim_period) - off;
         ps_on[i] = used[i] && (32'(rel) < duty_time);
         if (used[i]) k = k + 1;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sink_on <= '0;
         fb_select <= '0;
         boost_switch_on <= 1'b0;
         boost_min_output <= 1'b1;
         device_shutdown <= 1'b1;
      end else begin
         device_shutdown <= (state == LSD_OFF) || fault_shut || all_open;
         boost_min_output <= (state != LSD_RUN);
         fb_select <= live;
         if (state != LSD_RUN || fault_shut || all_open) begin
            sink_on <= '0;
            boost_switch_on <= 1'b0;
         end else begin
            sink_on <= live & (direct_mode ? {LSD_NSTR{dim_pwm_in}} : ps_on);
            boost_switch_on <= sw_gate && !output_overvoltage_sense && !switch_current_limit;
         end
      end
   end
endmodule

// ---- test/lsd_checker.sv ----
`timescale 1ns/1ps
module lsd_checker
   import lsd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable_pin,
   input wire logic dim_pwm_in,
   input wire logic dim_freq_mode_pin,
   input wire logic output_overvoltage_sense,
   input wire logic switch_cycle_start,
   input wire logic switch_current_limit,
   input wire logic output_short,
   input wire logic over_temperature,
   input wire logic [LSD_NSTR-1:0] sink_on,
   input wire logic [LSD_NSTR-1:0] fb_select,
   input wire logic boost_switch_on,
   input wire logic boost_min_output,
   input wire logic device_shutdown
);
   logic en_q;
   logic dir_mode;
   logic pwm_seen;
   // strap and pwm history of the current enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         dir_mode <= 1'b0;
         pwm_seen <= 1'b0;
      end else begin
         en_q <= enable_pin;
         if (enable_pin && !en_q) begin
            dir_mode <= dim_freq_mode_pin;
         end
         pwm_seen <= enable_pin && (pwm_seen || dim_pwm_in);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_off_dark: assert property (!enable_pin [*3] |-> sink_on == '0 && device_shutdown)
      else $error("sinks lit while disabled");
   a_ot_shut: assert property (over_temperature |-> ##[1:2] device_shutdown)
      else $error("no shutdown on over-temperature");
   a_short_shut: assert property (output_short |-> ##[1:2] device_shutdown)
      else $error("no shutdown on output short");
   a_ovp_inhibit: assert property (output_overvoltage_sense [*2] |-> !boost_switch_on)
      else $error("switching during over-voltage");
   a_limit_off: assert property (switch_current_limit ##1 !switch_cycle_start [*2] |-> !boost_switch_on)
      else $error("switch on after current limit");
   a_direct_follow: assert property (dir_mode && !device_shutdown && !boost_min_output
      && $past(!boost_min_output) && $stable(fb_select)
      |-> sink_on == (fb_select & {LSD_NSTR{$past(dim_pwm_in)}}))
      else $error("direct sinks off the input pwm");
   a_min_hold: assert property (enable_pin && !pwm_seen |-> boost_min_output && sink_on == '0)
      else $error("regulating before pwm");
   a_no_revive: assert property (!boost_min_output [*2] |-> (fb_select & ~$past(fb_select)) == '0)
      else $error("string revived without toggle");
   a_shut_dark: assert property (device_shutdown [*2] |-> sink_on == '0)
      else $error("sinks lit in shutdown");
endmodule
bind lsd_top lsd_checker u_chk (.*);

// ---- test/lsd_host.sv ----
`timescale 1ns/1ps
module lsd_host
   import lsd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en_req,
   input wire logic [15:0] period,
   input wire logic [15:0] high,
   output logic enable_pin,
   output logic dim_pwm_in
);
   logic [15:0] cnt;
   // enable level and pwm, none while high is zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         enable_pin <= 1'b0;
         dim_pwm_in <= 1'b0;
      end else begin
         enable_pin <= en_req;
         cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
         dim_pwm_in <= (cnt < high);
      end
   end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench
   import lsd_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strap, en_req, en, dim;
   logic cs, lim, osh, ot, ovs, sw, minout, shut;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [LSD_NSTR-1:0] fb, sov, sink, fbs;
   logic [15:0] per, hi;
   int mismatches, check_count, n0, n1;
   lsd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .enable_pin(en), .dim_pwm_in(dim), .dim_freq_mode_pin(strap),
      .string_sink_feedback(fb), .string_sink_overvoltage(sov), .output_overvoltage_sense(ovs),
      .switch_cycle_start(cs), .switch_current_limit(lim), .output_short(osh),
      .over_temperature(ot), .sink_on(sink), .fb_select(fbs), .boost_switch_on(sw),
      .boost_min_output(minout), .device_shutdown(shut));
   lsd_host u_host (.pclk(pclk), .presetn(presetn), .en_req(en_req), .period(per),
      .high(hi), .enable_pin(en), .dim_pwm_in(dim));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chkb(input logic got, input logic exp);
      chk({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk); // idle edge keeps back-to-back calls apart
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task toggle();
      en_req <= 1'b0;
      cyc(4);
      en_req <= 1'b1;
      cyc(4);
   endtask
   task wait_dim(input logic v);
      @(posedge pclk iff dim === v);
      cyc(2);
   endtask
   task wrap_up();
      if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_phase();
      logic [15:0] hs [3];
      logic [7:0] cd [3];
      hs = '{16'h007F, 16'h007E, 16'h007F};
      cd = '{8'h80, 8'h7E, 8'h7F};
      apb(1'b1, LSD_REG_PERIOD, 32'h0000_0100);
      apb(1'b0, 12'h0_FFC, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      strap <= 1'b0;
      hi <= 16'h0080;
      toggle();
      cyc(1100);
      apb(1'b0, LSD_REG_DUTY, 32'h0000_0000);
      chk(rd, 32'h0000_0080);
      apb(1'b0, LSD_REG_STATUS, 32'h0000_0000);
      chk(rd & 32'h003F_0001, 32'h000F_0000);
      n0 = 0;
      n1 = 0;
      repeat (256) begin
         @(posedge pclk);
         n0 += int'(sink[0]);
         n1 += int'(sink[0] & !sink[1]);
      end
      chk(32'(n0), 32'h0000_0080);
      chk(32'(n1), 32'h0000_0040);
      for (int i = 0; i < 3; i++) begin
         hi <= hs[i];
         cyc(1100);
         apb(1'b0, LSD_REG_DUTY, 32'h0000_0000);
         chk(rd, {24'h00_0000, cd[i]});
      end
   endtask
   task t_direct();
      strap <= 1'b1;
      per <= 16'h0020;
      hi <= 16'h0000;
      toggle();
      cyc(20);
      chk({25'h000_0000, minout, sink}, 32'h0000_0040);
      hi <= 16'h0010;
      cyc(40);
      wait_dim(1'b0);
      wait_dim(1'b1);
      chk({26'h000_0000, sink}, 32'h0000_000F);
      wait_dim(1'b0);
      chk({26'h000_0000, sink}, 32'h0000_0000);
      apb(1'b0, LSD_REG_STATUS, 32'h0000_0000);
      chk(rd & 32'h003F_0001, 32'h000F_0001);
      apb(1'b0, LSD_REG_DUTY, 32'h0000_0000);
      chk(rd, 32'h0000_007F);
   endtask
   task t_strings();
      fb <= 6'h0E;
      cyc(40);
      chk({26'h000_0000, fbs}, 32'h0000_000E);
      fb <= 6'h0F;
      cyc(40);
      chk({26'h000_0000, fbs}, 32'h0000_000E);
      sov <= 6'h02;
      cyc(2);
      sov <= 6'h00;
      cyc(40);
      chk({26'h000_0000, fbs}, 32'h0000_000C);
      toggle();
      wait_dim(1'b1);
      chk({26'h000_0000, fbs}, 32'h0000_000F);
      fb <= 6'h00;
      cyc(40);
      chkb(shut, 1'b1);
      fb <= 6'h0F;
      toggle();
   endtask
   task t_faults();
      for (int k = 0; k < 2; k++) begin
         wait_dim(1'b1);
         ot <= (k == 0);
         osh <= (k == 1);
         cyc(2);
         ot <= 1'b0;
         osh <= 1'b0;
         cyc(4);
         chkb(shut, 1'b1);
         toggle();
         wait_dim(1'b1);
         chkb(shut, 1'b0);
      end
      cs <= 1'b1;
      cyc(1);
      cs <= 1'b0;
      cyc(2);
      chkb(sw, 1'b1);
      ovs <= 1'b1;
      cyc(3);
      chkb(sw, 1'b0);
      ovs <= 1'b0;
      cyc(2);
      chkb(sw, 1'b1);
      apb(1'b1, LSD_REG_OCLIM, 32'h0000_0003);
      for (int i = 0; i < 3; i++) begin
         chkb(shut, 1'b0);
         cs <= 1'b1;
         cyc(1);
         cs <= 1'b0;
         cyc(2);
         lim <= 1'b1;
         cyc(1);
         lim <= 1'b0;
         cyc(3);
         chkb(sw, 1'b0);
      end
      chkb(shut, 1'b1);
   endtask
   // ----------------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      cyc(30000);
      mismatches++;
      wrap_up();
   end
   initial begin
      {psel, penable, pwrite, strap, en_req, cs, lim, osh, ot, ovs} = '0;
      paddr = 12'h0_000;
      pwdata = 32'h0000_0000;
      fb = 6'h0F;
      sov = 6'h00;
      per = 16'h0100;
      hi = 16'h0000;
      mismatches = 0;
      check_count = 0;
      presetn = 1'b0;
      cyc(4);
      presetn <= 1'b1;
      cyc(1);
      t_phase();
      t_direct();
      t_strings();
      t_faults();
      wrap_up();
   end
endmodule
